// ### hw/hsms_sequencer.sv
// sampling sequencer: mode select, conversion timing, output hold
`include "hsms_map.svh"

// How it works
// - a pin held low runs slow low-power sampling at about 24 Hz.
// - a floating pin reads low, so slow mode is the default.
// - a pin held high converts back to back at about 6.25 kHz.
// - in fast mode each conversion spans 16 internal ticks.
// - each pulse from outside starts one conversion, 24 Hz to 7.14 kHz.
// - an externally started conversion spans 14 internal ticks.
// - after the pin rises one tick passes as trigger delay, converter idle.
// - then the device stays awake 12 ticks to acquire and convert.
// - the last tick loads the result into the output and goes to sleep, or in fast mode starts the next conversion.
// - the output is marked invalid until power-on settling time passed.
// - each result is an 8-bit code, output level is code times supply/256.
module hsms_sequencer #(
    parameter int TICK_CYC = `HSMS_TICK_CYC,
    parameter int POR_CYC = `HSMS_POR_CYC,
    parameter int SLOW_TICKS = `HSMS_SLOW_TICKS,
    parameter int MODE_TICKS = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control pin, pin_present low means left floating
    input wire logic mode_trigger_pin,
    input wire logic pin_present,
    // converter sample input
    input wire logic [`HSMS_BITS-1:0] sample_code,
    // output stage
    output hsms_pkg::hsms_out_t out_stage,
    output hsms_pkg::hsms_mode_t mode,
    output logic sample_taken
);
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam int SW = $clog2(SLOW_TICKS + 1);
    localparam int PW = $clog2(POR_CYC + 1);

    hsms_pkg::hsms_state_t state_r, state_nxt;
    hsms_pkg::hsms_mode_t mode_r, mode_nxt;
    logic [TW-1:0] tick_cnt_r;
    logic [4:0] step_r, step_nxt;
    logic [SW-1:0] slow_cnt_r;
    logic [PW-1:0] por_cnt_r;
    logic [3:0] high_ticks_r;
    logic pin_prev_r, fast_r;
    logic [`HSMS_BITS-1:0] code_r;
    logic valid_r, awake_r;

    // floating pin reads as low through the pull-down
    wire pin_lvl = pin_present & mode_trigger_pin;
    wire tick = (tick_cnt_r == TW'(TICK_CYC - 1));
    wire rise = pin_lvl & ~pin_prev_r;
    wire por_done = (por_cnt_r == PW'(POR_CYC));
    wire slow_due = (slow_cnt_r == SW'(SLOW_TICKS - 1));
    // pin high for several ticks with no fall means held high
    wire held_high = (high_ticks_r >= 4'(MODE_TICKS));
    wire idle = (state_r == hsms_pkg::HSMS_SLEEP);
    wire in_update = (state_r == hsms_pkg::HSMS_UPDATE);
    wire mode_is_fast = (mode_r == hsms_pkg::HSMS_FAST);
    // length follows the mode latched at start, so a pin change mid-way
    // cannot move the end point behind the running step count
    wire [4:0] conv_len = mode_is_fast ? 5'(`HSMS_FAST_TICKS) :
        5'(`HSMS_EXT_TICKS);
    wire last = tick & (step_r == conv_len - 5'h01);
    wire done = last & in_update;
    // fast mode chains the next start onto the last update tick: 16 ticks apart
    wire start_ext = idle & rise & ~fast_r;
    wire start_fast = (idle | done) & tick & fast_r & held_high;
    wire start_slow = idle & tick & slow_due & ~pin_lvl;
    wire start = start_ext | start_fast | start_slow;

    always_comb begin
        state_nxt = state_r;
        step_nxt = step_r;
        mode_nxt = mode_r;
        if (start) begin
            state_nxt = hsms_pkg::HSMS_TRIG;
            step_nxt = 5'h00;
            mode_nxt = start_ext ? hsms_pkg::HSMS_EXT :
                       start_fast ? hsms_pkg::HSMS_FAST : hsms_pkg::HSMS_SLOW;
        end else if (!idle && tick) begin
            step_nxt = step_r + 5'h01;
            case (state_r)
                hsms_pkg::HSMS_TRIG: begin
                    state_nxt = hsms_pkg::HSMS_AWAKE;
                end
                hsms_pkg::HSMS_AWAKE: begin
                    if (step_r == 5'(`HSMS_AWAKE_TICKS)) begin
                        state_nxt = hsms_pkg::HSMS_UPDATE;
                    end
                end
                hsms_pkg::HSMS_UPDATE: begin
                    if (last) begin
                        state_nxt = hsms_pkg::HSMS_SLEEP;
                    end
                end
                default: begin
                    state_nxt = hsms_pkg::HSMS_SLEEP;
                end
            endcase
        end
    end

    // free-running internal clock divider
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
        end
    end

    // reset level matches the pulled-down pin, so no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= hsms_pkg::HSMS_SLEEP;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_r <= 5'h00;
        end else begin
            step_r <= step_nxt;
        end
    end

    // mode of the running or last conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= hsms_pkg::HSMS_SLOW;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // held-high detector, cleared by any low level
    always_ff @(posedge clk) begin
        if (rst || !pin_lvl) begin
            high_ticks_r <= 4'h0;
        end else if (tick && !held_high) begin
            high_ticks_r <= high_ticks_r + 4'h1;
        end
    end

    // fast mode is entered only between conversions
    always_ff @(posedge clk) begin
        if (rst || !pin_lvl) begin
            fast_r <= 1'b0;
        end else if (held_high && idle) begin
            fast_r <= 1'b1;
        end
    end

    // slow-mode sleep timer counts whole ticks
    always_ff @(posedge clk) begin
        if (rst || start) begin
            slow_cnt_r <= '0;
        end else if (tick && !slow_due) begin
            slow_cnt_r <= slow_cnt_r + SW'(1);
        end
    end

    // power-on settling gate
    always_ff @(posedge clk) begin
        if (rst) begin
            por_cnt_r <= '0;
        end else if (!por_done) begin
            por_cnt_r <= por_cnt_r + PW'(1);
        end
    end

    // result register: loaded only in the last update tick, held otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            code_r <= `HSMS_NULL_CODE;
        end else if (done) begin
            code_r <= sample_code;
        end
    end

    // a result finished before settling stays marked invalid
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_r <= 1'b0;
        end else if (done) begin
            valid_r <= por_done;
        end
    end

    // taken from the next state so it lines up with the state register
    always_ff @(posedge clk) begin
        if (rst) begin
            awake_r <= 1'b0;
        end else begin
            awake_r <= (state_nxt == hsms_pkg::HSMS_AWAKE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sample_taken <= 1'b0;
        end else begin
            sample_taken <= done;
        end
    end

    assign out_stage = '{code: code_r, valid: valid_r, awake: awake_r};
    assign mode = mode_r;
endmodule

// ### inc/hsms_map.svh
// timing counts and field widths of the sample mode sequencer
`ifndef HSMS_MAP_SVH
`define HSMS_MAP_SVH
`define HSMS_CLK_HZ 50000000
`define HSMS_TICK_NS 10000
`define HSMS_TICK_CYC ((`HSMS_TICK_NS * (`HSMS_CLK_HZ / 1000000)) / 1000)
`define HSMS_TRIG_TICKS 1
`define HSMS_AWAKE_TICKS 12
`define HSMS_UPD_TICKS 1
`define HSMS_EXT_TICKS 14
`define HSMS_FAST_TICKS 16
`define HSMS_SLOW_HZ 24
`define HSMS_SLOW_TICKS (1000000000 / (`HSMS_SLOW_HZ * `HSMS_TICK_NS))
`define HSMS_POR_NS 1000000
`define HSMS_POR_CYC ((`HSMS_POR_NS / 1000) * (`HSMS_CLK_HZ / 1000000))
`define HSMS_BITS 8
`define HSMS_NULL_CODE 8'h80
`endif

// ### inc/hsms_pkg.sv
// types of the sample mode sequencer
`include "hsms_map.svh"
package hsms_pkg;
    typedef enum logic [1:0] {
        HSMS_SLOW,
        HSMS_FAST,
        HSMS_EXT
    } hsms_mode_t;
    typedef enum logic [1:0] {
        HSMS_SLEEP,
        HSMS_TRIG,
        HSMS_AWAKE,
        HSMS_UPDATE
    } hsms_state_t;
    typedef struct packed {
        logic [`HSMS_BITS-1:0] code;
        logic valid;
        logic awake;
    } hsms_out_t;
endpackage

// ### sim/hsms_host.sv
// host model driving the control pin
module hsms_host (
    // clock and pattern
    input wire logic clk,
    input wire logic [1:0] sel,
    input wire logic [31:0] period,
    // control pin
    output logic pin,
    output logic present
);
    int cnt_r = 0;
    initial {pin, present} = 2'h0;
    always @(negedge clk) begin
        cnt_r <= (cnt_r + 1 >= period) ? 0 : cnt_r + 1;
        present <= (sel != 2'h0);
        // floating pin toggles so a leaked level never looks steady
        case (sel)
            2'h0: pin <= ~pin;
            2'h1: pin <= 1'b0;
            2'h2: pin <= 1'b1;
            default: pin <= (cnt_r < 12);
        endcase
    end
endmodule

// ### sim/hsms_seq_properties.sv
// assertions on the sequencer outputs
module hsms_seq_properties #(
    parameter int TICK_CYC = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // outputs
    input wire hsms_pkg::hsms_out_t out_stage,
    input wire logic sample_taken
);
    int aw_r;
    always_ff @(posedge clk) begin
        aw_r <= (rst || !out_stage.awake) ? 0 : aw_r + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_code_held: assert property (
        !$stable(out_stage.code) |-> ##[0:1] sample_taken) else $error("code");
    chk_taken_pulse: assert property (
        sample_taken |=> !sample_taken) else $error("pulse");
    chk_taken_asleep: assert property (
        sample_taken |-> !out_stage.awake) else $error("asleep");
    chk_awake_min: assert property (
        $rose(out_stage.awake) |-> out_stage.awake[*8]) else $error("awake");
    chk_awake_len: assert property (
        $fell(out_stage.awake) |-> aw_r == 12 * TICK_CYC) else $error("len");
    chk_trig_delay: assert property (
        $rose(out_stage.awake) |-> !$past(out_stage.awake, TICK_CYC))
        else $error("delay");
    chk_update_due: assert property (
        $fell(out_stage.awake) |-> ##[1:12] sample_taken) else $error("upd");
    chk_valid_kept: assert property (
        out_stage.valid |=> out_stage.valid) else $error("valid");
endmodule
bind hsms_sequencer hsms_seq_properties #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk(clk), .rst(rst), .out_stage(out_stage), .sample_taken(sample_taken));

// ### sim/tb_top.sv
// bench of the sample mode sequencer
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
fails++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int POR = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sel = 2'h1;
    logic [31:0] seed = 32'h8407;
    logic [7:0] sc = 8'h5A;
    logic pin;
    logic present;
    logic pin_q = 1'b0;
    logic taken;
    int period = 80;
    int cyc = 0;
    int rise = 0;
    int fails = 0;
    int samples_checked = 0;
    hsms_pkg::hsms_out_t outs;
    hsms_pkg::hsms_mode_t mode;
    initial forever #10 clk = ~clk;
    hsms_host u_host (.clk(clk), .sel(sel), .period(period), .pin(pin),
        .present(present));
    hsms_sequencer #(.TICK_CYC(TK), .POR_CYC(POR), .SLOW_TICKS(30),
        .MODE_TICKS(10)) u_dut (.clk(clk), .rst(rst), .mode_trigger_pin(pin),
        .pin_present(present), .sample_code(sc), .out_stage(outs),
        .mode(mode), .sample_taken(taken));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // results finished before settling after reset must read invalid
    function automatic logic exp_valid(input int now);
        return now > POR + 12;
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pin_q <= pin;
        if (pin && !pin_q) rise <= cyc;
    end
    // fr: span counted from the pin rise, not from the previous sample
    task automatic run(input logic [1:0] s, input bit fr, input int lo,
        input int hi, input hsms_pkg::hsms_mode_t m);
        int t;
        int w;
        sel = s;
        t = cyc;
        for (int i = 0; i < 4; i++) begin
            for (w = 0; taken !== 1'b1 && w < 900; w++) @(negedge clk);
            `CHK("due", 1'b1, w < 900)
            `CHK("code", sc, outs.code)
            `CHK("valid", exp_valid(cyc), outs.valid)
            // first samples may still belong to the previous mode
            if (i > 1) begin
                w = cyc - (fr ? rise : t);
                `CHK("mode", m, mode)
                `CHK("span", 1'b1, w inside {[lo:hi]})
            end
            t = cyc;
            sc = seed[7:0];
            seed = lfsr(seed);
            if (fr) period = 70 + int'(seed[5:0]);
            @(negedge clk);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        `CHK("null", 8'h80, outs.code)
        `CHK("valid", 1'b0, outs.valid)
        run(2'h1, 1'b0, 30 * TK, 30 * TK, hsms_pkg::HSMS_SLOW);
        run(2'h0, 1'b0, 30 * TK, 30 * TK, hsms_pkg::HSMS_SLOW);
        run(2'h2, 1'b0, 16 * TK, 16 * TK, hsms_pkg::HSMS_FAST);
        run(2'h3, 1'b1, 13 * TK + 2, 14 * TK + 1, hsms_pkg::HSMS_EXT);
        period = 36;
        run(2'h3, 1'b0, 14 * TK, 2 * 36, hsms_pkg::HSMS_EXT);
        report_and_stop();
    end
endmodule
